/* File: logic/cwd_pkg.sv */
package cwd_pkg;
    localparam logic [15:0] CWD_ADDR_WORD_ONE = 16'h8007;
    localparam logic [15:0] CWD_ADDR_WORD_TWO = 16'h8008;
    localparam logic [15:0] CWD_ADDR_CTRL = 16'h8009;
    localparam logic [15:0] CWD_ADDR_STATUS = 16'h800a;
    localparam logic [15:0] CWD_ADDR_ERASE = 16'h800b;
    localparam logic [13:0] CWD_WORD_RESET = 14'h3fff;
    localparam logic [13:0] CWD_ERASE_KEY = 14'h2a55;
    localparam int CWD_OSC_LSB = 0;
    localparam int CWD_UNIMPL_BIT = 2;
    localparam int CWD_WDT_LSB = 3;
    localparam int CWD_POWERUP_TIMER_BIT = 5;
    localparam int CWD_MCLR_BIT = 6;
    localparam int CWD_CP_BIT = 7;
    localparam int CWD_BOR_LSB = 9;
    localparam int CWD_CLKOUT_BIT = 11;
    localparam int CWD_DEBUG_BIT = 12;
    localparam int CWD_LVP_BIT = 13;
    localparam int CWD_SWDT_BIT = 0;
    localparam int CWD_SLEEP_BIT = 1;

    typedef enum logic [1:0] {
        CWD_ONOFF_OFF = 2'h0,
        CWD_ONOFF_SOFT = 2'h1,
        CWD_ONOFF_RUN = 2'h2,
        CWD_ONOFF_ON = 2'h3
    } cwd_mode_type;

    typedef struct packed {
        logic [1:0] oscillator_select_field;
        logic internal_oscillator;
        logic clock_input_pin;
        logic watchdog_active;
        logic brownout_active;
        logic powerup_timer;
        logic code_protect_bit;
        logic master_clear_pin_select;
        logic clock_output_pin_select;
    } cwd_settings_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cwd_wb_req_type;
endpackage

/* File: logic/cwd_config_word1_decoder.sv */
`timescale 1ns/1ns
// What this block does
// RULE1 - First configuration word lives at address 8007h.
// RULE2 - Second configuration word lives at next address, 8008h.
// RULE3 - Programmer keeps the debug enable bit at one.
// RULE4 - Bit 2 of word one is unimplemented and reads as one.
// RULE5 - Watchdog field 11 on, 10 run-only, 01 software, 00 off.
// RULE6 - Watchdog field 01 follows software enable in watchdog control.
// RULE7 - Oscillator field 11/10/01 external clock, 00 internal oscillator.
// RULE8 - Brown-out enable never turns on the power-up timer.
// RULE9 - Code protection clears only through a full bulk erase.
// RULE10 - Brown-out field 11 on, 10 run-only, 01 software, 00 off.
// RULE11 - Power-up timer enable is active low.
module cwd_config_word1_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cwd_pkg::cwd_wb_req_type wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output cwd_pkg::cwd_settings_type settings_o
);
    import cwd_pkg::*;

    logic [13:0] word_one;
    logic [13:0] word_two;
    logic [1:0] ctrl;
    logic [31:0] rdat;
    logic ack;
    cwd_settings_type settings;
    logic [13:0] next_word_one;
    logic [13:0] next_word_two;
    logic [1:0] next_ctrl;
    logic [31:0] next_rdat;
    logic next_ack;
    cwd_settings_type next_settings;
    logic req;
    logic [13:0] wdata;
    logic [13:0] word_one_view;
    cwd_mode_type wdt_mode;
    cwd_mode_type bor_mode;

    assign req = wb_i.cyc && wb_i.stb && !ack;
    assign wdata = wb_i.dat[13:0];
    assign wdt_mode = cwd_mode_type'(word_one[CWD_WDT_LSB +: 2]);
    assign bor_mode = cwd_mode_type'(word_one[CWD_BOR_LSB +: 2]);

    // RULE4 unimplemented reads one
    always_comb
    begin
        word_one_view = word_one;
        word_one_view[CWD_UNIMPL_BIT] = 1'b1;
    end

    always_comb
    begin
        next_word_one = word_one;
        next_word_two = word_two;
        next_ctrl = ctrl;
        if (req && wb_i.we && wb_i.sel[0] && wb_i.sel[1])
        begin
            case (wb_i.adr)
                // RULE1 word one programming
                CWD_ADDR_WORD_ONE:
                begin
                    // RULE9 protect bit sticks
                    // Program cells only clear bits; erase restores ones
                    next_word_one = word_one & wdata;
                    if (!word_one[CWD_CP_BIT])
                    begin
                        next_word_one[CWD_CP_BIT] = 1'b0;
                    end
                end
                // RULE2 word two slot
                CWD_ADDR_WORD_TWO:
                begin
                    next_word_two = word_two & wdata;
                end
                CWD_ADDR_CTRL:
                begin
                    next_ctrl = wb_i.dat[1:0];
                end
                // RULE9 bulk erase only
                CWD_ADDR_ERASE:
                begin
                    if (wdata == CWD_ERASE_KEY)
                    begin
                        next_word_one = CWD_WORD_RESET;
                        next_word_two = CWD_WORD_RESET;
                    end
                end
                default:
                begin
                    next_word_one = word_one;
                end
            endcase
        end
    end

    // RULE1 RULE2 read answer
    always_comb
    begin
        next_rdat = 32'h0;
        next_ack = req;
        if (req && !wb_i.we)
        begin
            case (wb_i.adr)
                CWD_ADDR_WORD_ONE: next_rdat = {18'h0, word_one_view};
                CWD_ADDR_WORD_TWO: next_rdat = {18'h0, word_two};
                CWD_ADDR_CTRL: next_rdat = {30'h0, ctrl};
                CWD_ADDR_STATUS: next_rdat = {22'h0, settings};
                default: next_rdat = 32'h0;
            endcase
        end
    end

    always_comb
    begin
        next_settings = settings;
        // RULE7 oscillator source
        next_settings.oscillator_select_field = word_one[CWD_OSC_LSB +: 2];
        next_settings.internal_oscillator = (word_one[CWD_OSC_LSB +: 2] == 2'h0);
        next_settings.clock_input_pin = (word_one[CWD_OSC_LSB +: 2] != 2'h0);
        // RULE5 watchdog mode decode
        case (wdt_mode)
            CWD_ONOFF_ON: next_settings.watchdog_active = 1'b1;
            CWD_ONOFF_RUN: next_settings.watchdog_active = !ctrl[CWD_SLEEP_BIT];
            // RULE6 software watchdog enable
            CWD_ONOFF_SOFT: next_settings.watchdog_active = ctrl[CWD_SWDT_BIT];
            default: next_settings.watchdog_active = 1'b0;
        endcase
        // RULE10 brown-out mode decode
        case (bor_mode)
            CWD_ONOFF_ON: next_settings.brownout_active = 1'b1;
            CWD_ONOFF_RUN: next_settings.brownout_active = !ctrl[CWD_SLEEP_BIT];
            CWD_ONOFF_SOFT: next_settings.brownout_active = ctrl[CWD_SWDT_BIT];
            default: next_settings.brownout_active = 1'b0;
        endcase
        // RULE8 RULE11 own bit only
        next_settings.powerup_timer = !word_one[CWD_POWERUP_TIMER_BIT];
        next_settings.code_protect_bit = !word_one[CWD_CP_BIT];
        next_settings.master_clear_pin_select = word_one[CWD_MCLR_BIT];
        next_settings.clock_output_pin_select = !word_one[CWD_CLKOUT_BIT];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            word_one <= CWD_WORD_RESET;
            word_two <= CWD_WORD_RESET;
            ctrl <= 2'h0;
        end
        else
        begin
            word_one <= next_word_one;
            word_two <= next_word_two;
            ctrl <= next_ctrl;
        end
    end

    // Answer flops drive the bus outputs directly
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat <= 32'h0;
            ack <= 1'b0;
        end
        else
        begin
            rdat <= next_rdat;
            ack <= next_ack;
        end
    end

    // Settings lag the word by one cycle; consumers see only settled levels
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            settings <= '0;
        end
        else
        begin
            settings <= next_settings;
        end
    end

    assign wb_dat_o = rdat;
    assign wb_ack_o = ack;
    assign settings_o = settings;

    // RULE3 debug bit kept high
    debug_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        word_two[CWD_DEBUG_BIT]) else $error("debug bit");
    sequence prot_set_s;
        !word_one[CWD_CP_BIT];
    endsequence
    sequence no_erase_s;
        !(req && wb_i.we && wb_i.adr == CWD_ADDR_ERASE);
    endsequence
    code_protect_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        prot_set_s and no_erase_s |=> !word_one[CWD_CP_BIT]) else $error("protect cleared");
    unimpl_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        ack && $past(wb_i.adr) == CWD_ADDR_WORD_ONE && !$past(wb_i.we) |-> rdat[2])
        else $error("bit two low");
    wdt_soft_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        wdt_mode == CWD_ONOFF_SOFT |=> settings.watchdog_active == $past(ctrl[CWD_SWDT_BIT]))
        else $error("soft watchdog");
    wdt_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        wdt_mode == CWD_ONOFF_OFF |=> !settings.watchdog_active) else $error("watchdog on");
    osc_int_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        word_one[1:0] == 2'h0 |=> settings.internal_oscillator && !settings.clock_input_pin)
        else $error("oscillator");
    powerup_timer_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        word_one[CWD_POWERUP_TIMER_BIT] |=> !settings.powerup_timer) else $error("powerup_timer");
    bor_powerup_timer_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        word_one[CWD_POWERUP_TIMER_BIT] && bor_mode == CWD_ONOFF_ON |=> !settings.powerup_timer)
        else $error("bor powerup_timer");
    bor_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        bor_mode == CWD_ONOFF_OFF |=> !settings.brownout_active) else $error("bor on");
    ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        ack |=> !ack) else $error("ack held");

    sequence write_ok_s;
        req && wb_i.we && wb_i.sel[0] && wb_i.sel[1];
    endsequence
    sequence erase_key_s;
        req && wb_i.we && wb_i.sel[0] && wb_i.sel[1] && wb_i.adr == CWD_ADDR_ERASE
            && wdata == CWD_ERASE_KEY;
    endsequence
    sequence sel_refused_s;
        req && wb_i.we && !(wb_i.sel[0] && wb_i.sel[1]);
    endsequence

    // RULE1 one answer per request
    ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        req |=> ack) else $error("no ack");
    read_idle_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        !ack |-> rdat == 32'h0) else $error("data without ack");
    // RULE4 word one read view
    word_one_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        req && !wb_i.we && wb_i.adr == CWD_ADDR_WORD_ONE
        |=> rdat[13:0] == ($past(word_one) | 14'h4)) else $error("word one read");
    status_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        req && !wb_i.we && wb_i.adr == CWD_ADDR_STATUS
        |=> rdat == {22'h0, $past(settings)}) else $error("status read");

    // RULE9 erase and programming
    erase_ones_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        erase_key_s |=> word_one == CWD_WORD_RESET && word_two == CWD_WORD_RESET)
        else $error("erase incomplete");
    // Without an erase no word one cell may go from zero back to one
    program_clears_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        !(req && wb_i.we && wb_i.adr == CWD_ADDR_ERASE)
        |=> (word_one & ~$past(word_one)) == 14'h0) else $error("bit set by write");
    refused_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        sel_refused_s |=> word_one == $past(word_one) && word_two == $past(word_two))
        else $error("refused write landed");
    // RULE2 word two programming
    word_two_prog_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
        write_ok_s ##0 (wb_i.adr == CWD_ADDR_WORD_TWO)
        |=> word_two == ($past(word_two) & $past(wdata))) else $error("word two");

    // RULE5 RULE6 watchdog decode
    wdt_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        wdt_mode == CWD_ONOFF_ON |=> settings.watchdog_active) else $error("watchdog off");
    wdt_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        wdt_mode == CWD_ONOFF_RUN |=> settings.watchdog_active == !$past(ctrl[CWD_SLEEP_BIT]))
        else $error("watchdog run");

    // RULE7 oscillator decode
    osc_ext_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        word_one[1:0] != 2'h0 |=> settings.clock_input_pin && !settings.internal_oscillator)
        else $error("external clock");
    osc_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        1'b1 |=> settings.oscillator_select_field == $past(word_one[1:0]))
        else $error("oscillator field");

    // RULE10 brown-out decode
    bor_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        bor_mode == CWD_ONOFF_ON |=> settings.brownout_active) else $error("bor off");
    bor_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        bor_mode == CWD_ONOFF_RUN |=> settings.brownout_active == !$past(ctrl[CWD_SLEEP_BIT]))
        else $error("bor run");
    bor_soft_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        bor_mode == CWD_ONOFF_SOFT |=> settings.brownout_active == $past(ctrl[CWD_SWDT_BIT]))
        else $error("bor soft");

    // RULE11 power-up timer active low
    powerup_timer_on_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        !word_one[CWD_POWERUP_TIMER_BIT] |=> settings.powerup_timer) else $error("powerup_timer off");
    // RULE9 protection reported
    cp_report_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        1'b1 |=> settings.code_protect_bit == !$past(word_one[CWD_CP_BIT]))
        else $error("protect report");
    pin_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        1'b1 |=> settings.master_clear_pin_select == $past(word_one[CWD_MCLR_BIT])
        && settings.clock_output_pin_select == !$past(word_one[CWD_CLKOUT_BIT]))
        else $error("pin select");
endmodule

/* File: verif/cwd_prog_model.sv */
`timescale 1ns/1ns
module cwd_prog_model (
    input wire logic clk_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i,
    output cwd_pkg::cwd_wb_req_type wb_o
);
    import cwd_pkg::*;
    initial wb_o = '0;
    // One classic cycle; waits on ack, the bench timeout ends a hang
    task automatic xfer(input logic we, input logic [15:0] adr, input logic [13:0] d,
        output logic [31:0] q);
        logic [13:0] v;
        v = d;
        if (we && adr == CWD_ADDR_WORD_TWO)
            v[CWD_DEBUG_BIT] = 1'b1;
        @(posedge clk_i);
        wb_o <= '{1'b1, 1'b1, we, adr, 4'hf, {18'h0, v}};
        do
            @(posedge clk_i);
        while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_o <= '0;
    endtask
endmodule

/* File: verif/cwd_config_word1_decoder_tb.sv */
`timescale 1ns/1ns
module cwd_config_word1_decoder_tb;
    import cwd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cwd_wb_req_type wb;
    logic [31:0] dat;
    logic ack;
    cwd_settings_type st;
    logic [31:0] q;
    logic [13:0] w;
    logic [1:0] m;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    cwd_config_word1_decoder u_cwd_config_word1_decoder (.clk_i(clk_i), .rst_i(rst_i),
        .wb_i(wb), .wb_dat_o(dat), .wb_ack_o(ack), .settings_o(st));
    cwd_prog_model u_cwd_prog_model (.clk_i(clk_i), .wb_dat_i(dat), .wb_ack_i(ack),
        .wb_o(wb));
    initial forever #10 clk_i = ~clk_i;
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [13:0] d);
        u_cwd_prog_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
        u_cwd_prog_model.xfer(1'b0, a, 14'h0, q);
        check(nm, exp, q);
    endtask
    function automatic logic act(input logic [1:0] f, input logic [1:0] c);
        return f == 2'h3 || (f == 2'h2 && !c[1]) || (f == 2'h1 && c[0]);
    endfunction
    task automatic wrap_up;
        $display("errors %0d cmp_count %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Cut a hang short well above the expected 180 or so cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(CWD_ADDR_WORD_ONE, 32'h3fff, "word_one");
        rd(CWD_ADDR_WORD_TWO, 32'h3fff, "word_two");
        wr(16'h1234, 14'h0);
        rd(16'h1234, 32'h0, "unmapped");
        wr(CWD_ADDR_WORD_TWO, 14'h0ffe);
        rd(CWD_ADDR_WORD_TWO, 32'h1ffe, "word_two");
        // every field code, each control setting
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            wr(CWD_ADDR_ERASE, CWD_ERASE_KEY);
            w = {2'b11, m[1], m, 1'b1, m[1], m[0], m[0], m, 1'b0, m};
            wr(CWD_ADDR_WORD_ONE, w);
            rd(CWD_ADDR_WORD_ONE, {18'h0, w | 14'h4}, "word_one");
            for (int c = 0; c < 4; c++)
            begin
                wr(CWD_ADDR_CTRL, {12'h0, c[1:0]});
                repeat (2) @(posedge clk_i);
                check("settings", {m, m == 2'h0, m != 2'h0, act(m, c[1:0]), act(m, c[1:0]),
                    ~m[0], ~m[1], m[0], ~m[1]}, st);
            end
        end
        // rewrite and wrong key leave protection set
        wr(CWD_ADDR_ERASE, CWD_ERASE_KEY);
        wr(CWD_ADDR_WORD_ONE, 14'h3f7f);
        wr(CWD_ADDR_WORD_ONE, 14'h3fff);
        wr(CWD_ADDR_ERASE, 14'h0);
        repeat (2) @(posedge clk_i);
        check("protect", 32'h1, st.code_protect_bit);
        rd(CWD_ADDR_WORD_ONE, 32'h3f7f, "word_one");
        wr(CWD_ADDR_ERASE, CWD_ERASE_KEY);
        repeat (2) @(posedge clk_i);
        check("protect", 32'h0, st.code_protect_bit);
        rd(CWD_ADDR_WORD_ONE, 32'h3fff, "word_one");
        rd(CWD_ADDR_STATUS, 32'h372, "status");
        wrap_up();
    end
endmodule
